// [core/synth_cfg_pkg.sv]
// Package for the synthesizer and modem configuration register group.
// Assumes a byte-wide register port fed by the serial configuration front end.
package synth_cfg_pkg;

    // =========================================================================
    // Register offsets on the configuration port.
    localparam logic [5:0] ADDR_SYNTH_CTRL_IF = 6'h0b;
    localparam logic [5:0] ADDR_SYNTH_CTRL_OFFSET = 6'h0c;
    localparam logic [5:0] ADDR_BASE_SYNTH_BASE_WORD_HIGH = 6'h0d;
    localparam logic [5:0] ADDR_BASE_SYNTH_BASE_WORD_MID = 6'h0e;
    localparam logic [5:0] ADDR_BASE_SYNTH_BASE_WORD_LOW = 6'h0f;
    localparam logic [5:0] ADDR_MODEM_BW_RATE_EXP = 6'h10;
    localparam logic [5:0] ADDR_MODEM_RATE_MANTISSA = 6'h11;

    // =========================================================================
    // Values after reset.
    localparam logic [7:0] RST_SYNTH_CTRL_IF = 8'h0f;
    localparam logic [7:0] RST_SYNTH_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RST_BASE_SYNTH_BASE_WORD_HIGH = 8'h1e;
    localparam logic [7:0] RST_BASE_SYNTH_BASE_WORD_MID = 8'hc4;
    localparam logic [7:0] RST_BASE_SYNTH_BASE_WORD_LOW = 8'hec;
    localparam logic [7:0] RST_MODEM_BW_RATE_EXP = 8'h8c;
    localparam logic [7:0] RST_MODEM_RATE_MANTISSA = 8'h22;

    // =========================================================================
    // Writable masks; cleared bits are unused or read-only and read as zero.
    localparam logic [7:0] MASK_SYNTH_CTRL_IF = 8'h3f;
    localparam logic [7:0] MASK_BASE_SYNTH_BASE_WORD_HIGH = 8'h3f;

    // =========================================================================
    // Field positions.
    localparam int IF_CODE_MSB = 4;
    localparam int BW_EXP_LSB = 6;
    localparam int BW_MANT_LSB = 4;
    localparam int RATE_EXP_MSB = 3;

    // =========================================================================
    // Scale steps relative to the base word unit (crystal / 2^16).
    localparam int IF_SHIFT = 6;     // Crystal / 2^10 is 64 base units.
    localparam int OFFSET_SHIFT = 2; // Crystal / 2^14 is 4 base units.
    localparam logic [2:0] BW_MANT_BIAS = 3'h4;
    localparam int BW_FIXED_SHIFT = 3; // The factor 8 in the divisor.
    localparam logic HIDDEN_RATE_BIT = 1'b1; // Implied 256 of the mantissa.

    // Constants handed to synthesizer, mixer, decimator and demodulator.
    typedef struct packed {
        logic [4:0] intermediateCode;
        logic [7:0] synthOffset;
        logic [23:0] synthBaseWord;
        logic [24:0] rxSynthWord;     // Signed, base + offset - IF.
        logic [1:0] bandwidthExponent;
        logic [1:0] bandwidthMantissa;
        logic [8:0] decimationRatio;  // 8 x (4 + M) x 2^E.
        logic [3:0] symbolRateExponent;
        logic [8:0] symbolRateMantissa; // Hidden one on top.
    } synth_cfg_t;

endpackage

// [core/synth_modem_config_regs.sv]
// Configuration registers for synthesizer frequency, channel bandwidth and
// symbol rate, with the derived constants for the receive datapath.
// Assumes the serial configuration front end runs on clk and presents
// one-cycle read and write strobes with a 6-bit address.

// =============================================================================
// Overview of operation
// - IF code, reset 15, sets IF and mixer
// - Signed offset added to base, step crystal/2^14
// - Three bytes form 24-bit base frequency word
// - Top two base bits read-only, read zero
// - Bandwidth exponent and mantissa set decimation ratio
// - Symbol rate exponent in low nibble, reset 12
// - Rate mantissa nine bits with hidden one
module synth_modem_config_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output synth_cfg_pkg::synth_cfg_t cfgOut
);

    // =========================================================================
    // Register storage.
    logic [7:0] synthCtrlIf_ff;     // Bit 5 kept as written, 4:0 the IF code.
    logic [7:0] synthCtrlOffset_ff; // Two's-complement offset.
    logic [7:0] baseFreqHigh_ff;    // Bits 7:6 never set.
    logic [7:0] baseFreqMid_ff;
    logic [7:0] baseFreqLow_ff;
    logic [7:0] modemBwRateExp_ff;
    logic [7:0] modemRateMantissa_ff;
    logic [7:0] rdData_ff;
    logic rdValid_ff;
    synth_cfg_pkg::synth_cfg_t cfg_ff;

    // =========================================================================
    // Address decode; each strobe hits at most one register.
    wire hitIf = regAddr == synth_cfg_pkg::ADDR_SYNTH_CTRL_IF;
    wire hitOff = regAddr == synth_cfg_pkg::ADDR_SYNTH_CTRL_OFFSET;
    wire hitHigh = regAddr == synth_cfg_pkg::ADDR_BASE_SYNTH_BASE_WORD_HIGH;
    wire hitMid = regAddr == synth_cfg_pkg::ADDR_BASE_SYNTH_BASE_WORD_MID;
    wire hitLow = regAddr == synth_cfg_pkg::ADDR_BASE_SYNTH_BASE_WORD_LOW;
    wire hitBw = regAddr == synth_cfg_pkg::ADDR_MODEM_BW_RATE_EXP;
    wire hitRate = regAddr == synth_cfg_pkg::ADDR_MODEM_RATE_MANTISSA;

    // Any mapped register; a write that hits none must leave every register alone.
    wire anyHit = hitIf || hitOff || hitHigh || hitMid || hitLow || hitBw || hitRate;

    // Read select; an unmapped address answers zero.
    logic [7:0] rdSel;
    assign rdSel = hitIf ? synthCtrlIf_ff :
                   hitOff ? synthCtrlOffset_ff :
                   hitHigh ? baseFreqHigh_ff :
                   hitMid ? baseFreqMid_ff :
                   hitLow ? baseFreqLow_ff :
                   hitBw ? modemBwRateExp_ff :
                   hitRate ? modemRateMantissa_ff : 8'h00;

    // =========================================================================
    // Register writes. Masks drop writes to unused and read-only bits.
    always_ff @(posedge clk) begin
        if (reset) begin
            synthCtrlIf_ff <= synth_cfg_pkg::RST_SYNTH_CTRL_IF;
            synthCtrlOffset_ff <= synth_cfg_pkg::RST_SYNTH_CTRL_OFFSET;
            baseFreqHigh_ff <= synth_cfg_pkg::RST_BASE_SYNTH_BASE_WORD_HIGH;
            baseFreqMid_ff <= synth_cfg_pkg::RST_BASE_SYNTH_BASE_WORD_MID;
            baseFreqLow_ff <= synth_cfg_pkg::RST_BASE_SYNTH_BASE_WORD_LOW;
            modemBwRateExp_ff <= synth_cfg_pkg::RST_MODEM_BW_RATE_EXP;
            modemRateMantissa_ff <= synth_cfg_pkg::RST_MODEM_RATE_MANTISSA;
        end else if (regWrEn) begin
            if (hitIf) begin
                synthCtrlIf_ff <= regWrData & synth_cfg_pkg::MASK_SYNTH_CTRL_IF;
            end
            if (hitOff) begin
                synthCtrlOffset_ff <= regWrData;
            end
            if (hitHigh) begin
                baseFreqHigh_ff <= regWrData & synth_cfg_pkg::MASK_BASE_SYNTH_BASE_WORD_HIGH;
            end
            if (hitMid) begin
                baseFreqMid_ff <= regWrData;
            end
            if (hitLow) begin
                baseFreqLow_ff <= regWrData;
            end
            if (hitBw) begin
                modemBwRateExp_ff <= regWrData;
            end
            if (hitRate) begin
                modemRateMantissa_ff <= regWrData;
            end
        end
    end

    // =========================================================================
    // Read answer, one cycle after the strobe, held until the next read.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_ff <= 8'h00;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= regRdEn;
            if (regRdEn) begin
                rdData_ff <= rdSel;
            end
        end
    end

    // =========================================================================
    // Derived constants for the datapath.
    wire [4:0] ifCode = synthCtrlIf_ff[synth_cfg_pkg::IF_CODE_MSB:0];
    wire [23:0] baseWord = {baseFreqHigh_ff, baseFreqMid_ff, baseFreqLow_ff};
    wire [1:0] bwExp = modemBwRateExp_ff[synth_cfg_pkg::BW_EXP_LSB +: 2];
    wire [1:0] bwMant = modemBwRateExp_ff[synth_cfg_pkg::BW_MANT_LSB +: 2];

    // Offset sign-extended and scaled by 4 base units. The size cast keeps the
    // sign, so a negative offset pulls the word down rather than wrapping it up.
    wire [24:0] offsetTerm =
        25'(signed'(synthCtrlOffset_ff)) <<< synth_cfg_pkg::OFFSET_SHIFT;
    // IF code scaled by 64 base units, subtracted in receive.
    wire [24:0] ifTerm = 25'(ifCode) << synth_cfg_pkg::IF_SHIFT;
    // The sum wraps within 25 bits; the top bit is the sign of the result.
    wire [24:0] rxWord = 25'({1'b0, baseWord} + offsetTerm - ifTerm);

    // Decimation ratio 8 x (4 + M) x 2^E; the largest value 448 fits 9 bits.
    // The biased mantissa is at most 7, so three bits hold it without loss.
    wire [2:0] bwDiv = 3'(synth_cfg_pkg::BW_MANT_BIAS + 3'(bwMant));
    wire [8:0] decim = 9'(9'(bwDiv) << (synth_cfg_pkg::BW_FIXED_SHIFT + int'(bwExp)));

    // Registered outputs so downstream blocks see a clean constant.
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff.intermediateCode <= ifCode;
            cfg_ff.synthOffset <= synthCtrlOffset_ff;
            cfg_ff.synthBaseWord <= baseWord;
            cfg_ff.rxSynthWord <= rxWord;
            cfg_ff.bandwidthExponent <= bwExp;
            cfg_ff.bandwidthMantissa <= bwMant;
            cfg_ff.decimationRatio <= decim;
            cfg_ff.symbolRateExponent <=
                modemBwRateExp_ff[synth_cfg_pkg::RATE_EXP_MSB:0];
            cfg_ff.symbolRateMantissa <= {synth_cfg_pkg::HIDDEN_RATE_BIT,
                                          modemRateMantissa_ff};
        end
    end

    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;
    assign cfgOut = cfg_ff;

    // =========================================================================
    // Assertions.
    // A write lands in its register at the strobe edge and reaches the
    // datapath constants one edge later, so write checks look two edges on.
    // All but the two reset-value checks are off while reset stands.
    sequence s_write_if;
        regWrEn && hitIf;
    endsequence

    sequence s_write_high;
        regWrEn && hitHigh;
    endsequence

    sequence s_write_off;
        regWrEn && hitOff;
    endsequence

    sequence s_write_mid;
        regWrEn && hitMid;
    endsequence

    sequence s_write_low;
        regWrEn && hitLow;
    endsequence

    sequence s_write_bw;
        regWrEn && hitBw;
    endsequence

    sequence s_write_rate;
        regWrEn && hitRate;
    endsequence

    // A write that hits no register; it must change nothing.
    sequence s_write_none;
        regWrEn && !anyHit;
    endsequence

    // The IF code handed to the mixer follows its write.
    a_if_code_write: assert property (@(posedge clk) disable iff (reset)
        s_write_if |=> ##1 cfgOut.intermediateCode == $past(regWrData[4:0], 2))
        else $error("IF code did not follow a write");

    // The receive word is base plus scaled offset minus scaled IF.
    a_offset_scaled: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> cfgOut.rxSynthWord == 25'({1'b0, $past(baseWord)}
            + (25'(signed'($past(synthCtrlOffset_ff))) <<< 2)
            - (25'($past(ifCode)) << 6)))
        else $error("Receive synthesizer word is wrong");

    // The three bytes join high to low, with the top pair forced to zero.
    a_base_word_join: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> cfgOut.synthBaseWord == {2'h0, $past(baseFreqHigh_ff[5:0]),
            $past(baseFreqMid_ff), $past(baseFreqLow_ff)})
        else $error("Base word does not join the three bytes");

    // A write to the high byte keeps only its low six bits.
    a_high_top_zero: assert property (@(posedge clk) disable iff (reset)
        s_write_high |=> baseFreqHigh_ff[7:6] == 2'b00
            && baseFreqHigh_ff[5:0] == $past(regWrData[5:0]))
        else $error("High base byte top bits not zero");

    // The decimation ratio follows the bandwidth fields one edge later.
    a_bw_ratio: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> cfgOut.decimationRatio
            == 9'((8 * (4 + int'($past(bwMant)))) << $past(bwExp)))
        else $error("Decimation ratio is wrong");

    // The symbol rate exponent leaves reset at 12.
    a_rate_exp_reset: assert property (@(posedge clk)
        $fell(reset) |-> modemBwRateExp_ff[3:0] == 4'hc)
        else $error("Rate exponent reset is not 12");

    // Once loaded after reset, the rate mantissa carries the implied top one.
    a_rate_hidden_one: assert property (@(posedge clk) disable iff (reset)
        $past(reset) == 1'b0 |-> cfgOut.symbolRateMantissa[8] == 1'b1
            && cfgOut.symbolRateMantissa[7:0] == $past(modemRateMantissa_ff))
        else $error("Rate mantissa lacks the hidden one");

    // The middle byte written and then read back returns what was written.
    a_read_back_mid: assert property (@(posedge clk) disable iff (reset)
        regWrEn && hitMid ##1 regRdEn && !regWrEn && hitMid
            |=> regRdValid && regRdData == $past(regWrData, 2))
        else $error("Middle byte did not read back");

    // A read above the group answers zero.
    a_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
        regRdEn && regAddr > 6'h11 |=> regRdData == 8'h00)
        else $error("Unmapped read is not zero");

    // The IF code comes out of reset at 15 before any write can reach it.
    a_if_reset_value: assert property (@(posedge clk)
        $fell(reset) |-> synthCtrlIf_ff[4:0] == 5'h0f)
        else $error("IF code reset is not 15");

    // The unused top pair of the IF register is never stored.
    a_if_top_zero: assert property (@(posedge clk) disable iff (reset)
        synthCtrlIf_ff[7:6] == 2'h0)
        else $error("Unused IF register bits were stored");

    // The offset reaches the datapath two edges after its write.
    a_offset_write: assert property (@(posedge clk) disable iff (reset)
        s_write_off |=> ##1 cfgOut.synthOffset == $past(regWrData, 2))
        else $error("Offset did not follow a write");

    // The middle byte lands in bits 15:8 of the base word.
    a_mid_write: assert property (@(posedge clk) disable iff (reset)
        s_write_mid |=> ##1 cfgOut.synthBaseWord[15:8] == $past(regWrData, 2))
        else $error("Middle base byte did not follow a write");

    // The low byte lands in bits 7:0 of the base word.
    a_low_write: assert property (@(posedge clk) disable iff (reset)
        s_write_low |=> ##1 cfgOut.synthBaseWord[7:0] == $past(regWrData, 2))
        else $error("Low base byte did not follow a write");

    // The top pair of the base word is zero in the register and downstream.
    a_high_always_zero: assert property (@(posedge clk) disable iff (reset)
        baseFreqHigh_ff[7:6] == 2'h0 && cfgOut.synthBaseWord[23:22] == 2'h0)
        else $error("Base word top bits not zero");

    // Exponent and mantissa of the bandwidth follow their write.
    a_bw_fields: assert property (@(posedge clk) disable iff (reset)
        s_write_bw |=> ##1 cfgOut.bandwidthExponent == $past(regWrData[7:6], 2)
            && cfgOut.bandwidthMantissa == $past(regWrData[5:4], 2))
        else $error("Bandwidth fields did not follow a write");

    // The symbol rate exponent is the low nibble of the same register.
    a_rate_exp_write: assert property (@(posedge clk) disable iff (reset)
        s_write_bw |=> ##1 cfgOut.symbolRateExponent == $past(regWrData[3:0], 2))
        else $error("Rate exponent did not follow a write");

    // A written mantissa comes out under the implied one.
    a_rate_mant_write: assert property (@(posedge clk) disable iff (reset)
        s_write_rate |=> ##1 cfgOut.symbolRateMantissa == {1'h1, $past(regWrData, 2)})
        else $error("Rate mantissa did not follow a write");

    // Every read strobe is answered by a valid pulse one edge later.
    a_rd_valid_high: assert property (@(posedge clk) disable iff (reset)
        regRdEn |=> regRdValid)
        else $error("Read was not answered");

    // No valid pulse appears without a read strobe.
    a_rd_valid_low: assert property (@(posedge clk) disable iff (reset)
        !regRdEn |=> !regRdValid)
        else $error("Valid pulse without a read");

    // Read data stands until the next read.
    a_rd_data_hold: assert property (@(posedge clk) disable iff (reset)
        !regRdEn |=> $stable(regRdData))
        else $error("Read data changed without a read");

    // A write outside the group leaves every register as it was.
    a_unmapped_write_kept: assert property (@(posedge clk) disable iff (reset)
        s_write_none |=> $stable(synthCtrlIf_ff) && $stable(synthCtrlOffset_ff)
            && $stable(baseFreqHigh_ff) && $stable(baseFreqMid_ff)
            && $stable(baseFreqLow_ff) && $stable(modemBwRateExp_ff)
            && $stable(modemRateMantissa_ff))
        else $error("Unmapped write changed a register");

endmodule // synth_modem_config_regs

// [testbench/synth_modem_config_regs_tb.sv]
// Self-checking bench for the synthesizer and modem configuration registers.
// Assumes the register port contract: strobes taken on rising clk, read data
// one cycle later, derived constants two edges after a write.

// ===========================================================================
// Comparison helper; counts every compare and reports any mismatch.
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        errors++; \
        $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
end

module synth_modem_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ===========================================================================
    // Stimulus and observation signals.
    logic clk;
    logic reset = 1'h1; // Held high from time zero.
    logic [5:0] regAddr = 6'h00;
    logic regWrEn = 1'h0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'h0;
    logic [7:0] regRdData;
    logic regRdValid;
    synth_cfg_pkg::synth_cfg_t cfgOut;
    int errors = 0; // Mismatches seen so far.
    int samples_checked = 0; // Comparisons made so far.
    int cycleCount = 0; // Guards against a hung wait.
    localparam int CYCLE_LIMIT = 2000; // The whole run needs about 55 cycles.
    // Reset values and writable masks of 0x0b..0x11, in address order.
    logic [7:0] rstTab [7] = '{8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22};
    logic [7:0] maskTab [7] = '{8'h3f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff};

    synth_modem_config_regs i_synth_modem_config_regs (
        .clk(clk),
        .reset(reset),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .regRdValid(regRdValid),
        .cfgOut(cfgOut)
    );

    // ===========================================================================
    // Clock of 4 ns and the run-length guard.
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // A stuck bench counts as a failure rather than running on forever.
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == CYCLE_LIMIT) begin
            errors++;
            give_verdict();
        end
    end

    // ===========================================================================
    // Bus tasks; each is entered and left at a falling edge.
    // Strobes are left standing; the next task or an idle step sets them, so no
    // signal is driven twice in one time step.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        regRdEn = 1'h0;
        @(negedge clk);
    endtask

    // Read data is taken one cycle after the strobe, while the valid flag stands.
    task automatic rdChk(input logic [5:0] a, input logic [7:0] ex);
        regAddr = a;
        regWrEn = 1'h0;
        regRdEn = 1'h1;
        @(negedge clk);
        `CHK("regRdValid", 1'h1, regRdValid)
        `CHK("regRdData", ex, regRdData)
    endtask

    // ===========================================================================
    // Scenarios.
    // Every register and the derived constants other than synthOffset and the bandwidth fields must show their reset values.
    task automatic testReset();
        for (int i = 0; i < 7; i++) begin
            rdChk(6'h0b + 6'(i), rstTab[i]);
        end
        `CHK("intermediateCode", 5'h0f, cfgOut.intermediateCode)
        `CHK("synthBaseWord", 24'h1e_c4ec, cfgOut.synthBaseWord)
        `CHK("rxSynthWord", 25'h01e_c12c, cfgOut.rxSynthWord)
        `CHK("decimationRatio", 9'h080, cfgOut.decimationRatio)
        `CHK("symbolRateExponent", 4'hc, cfgOut.symbolRateExponent)
        `CHK("symbolRateMantissa", 9'h122, cfgOut.symbolRateMantissa)
    endtask

    // All-ones writes leave only writable bits; an unmapped place stays zero.
    task automatic testMasks();
        for (int i = 0; i < 7; i++) begin
            wr(6'h0b + 6'(i), 8'hff);
            rdChk(6'h0b + 6'(i), maskTab[i]);
        end
        wr(6'h12, 8'ha5);
        rdChk(6'h12, 8'h00);
    endtask

    // Program every field and compare the derived constants with the formulas.
    task automatic setChk(input logic [4:0] code, input logic [7:0] off,
                          input logic [21:0] base, input logic [7:0] bw,
                          input logic [7:0] mant);
        logic [24:0] rx;
        logic [8:0] ratio;
        rx = {3'h0, base} + {{15{off[7]}}, off, 2'h0} - {14'h0, code, 6'h00};
        ratio = (9'h008 * (9'h004 + {7'h00, bw[5:4]})) << bw[7:6];
        wr(6'h0b, {3'h0, code});
        wr(6'h0c, off);
        wr(6'h0d, {2'h3, base[21:16]}); // Top bits must be dropped.
        wr(6'h0e, base[15:8]);
        wr(6'h0f, base[7:0]);
        wr(6'h10, bw);
        wr(6'h11, mant);
        regWrEn = 1'h0; // Idle while the constants settle.
        repeat (2) @(negedge clk);
        `CHK("regRdValid", 1'h0, regRdValid)
        `CHK("intermediateCode", code, cfgOut.intermediateCode)
        `CHK("synthOffset", off, cfgOut.synthOffset)
        `CHK("synthBaseWord", {2'h0, base}, cfgOut.synthBaseWord)
        `CHK("rxSynthWord", rx, cfgOut.rxSynthWord)
        `CHK("bandwidthExponent", bw[7:6], cfgOut.bandwidthExponent)
        `CHK("bandwidthMantissa", bw[5:4], cfgOut.bandwidthMantissa)
        `CHK("decimationRatio", ratio, cfgOut.decimationRatio)
        `CHK("symbolRateExponent", bw[3:0], cfgOut.symbolRateExponent)
        `CHK("symbolRateMantissa", {1'h1, mant}, cfgOut.symbolRateMantissa)
    endtask

    // A read and a write in the same cycle return the old contents.
    task automatic testSameCycle();
        regAddr = 6'h0e;
        regWrData = 8'h5a;
        regWrEn = 1'h1;
        regRdEn = 1'h1;
        @(negedge clk);
        `CHK("regRdData", 8'h3b, regRdData)
        rdChk(6'h0e, 8'h5a);
    endtask

    // ===========================================================================
    // Verdict, printed once from here only.
    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence: reset for two cycles, then the scenarios in turn.
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'h0;
        @(negedge clk);
        testReset();
        testMasks();
        setChk(5'h1f, 8'h80, 22'h3f_ffff, 8'hff, 8'h00); // Extreme negative case.
        setChk(5'h00, 8'h7f, 22'h00_0001, 8'h00, 8'hff); // Extreme positive case.
        setChk(5'h0a, 8'hfe, 22'h21_3b01, 8'h5a, 8'h7c); // Mixed case.
        testSameCycle();
        give_verdict();
    end
endmodule // synth_modem_config_regs_tb
